// *** hdl/pwm_sync_assist.sv ***
// Device end: timers, capture, compare and line drive behind an AXI4-Lite slave
`timescale 1ns/1ps
module pwm_sync_assist
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [31:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic irq,
  output logic wake,
  pwm_bus_if.device bus
);
  localparam logic [5:0] FAST_LAST = 6'(pwm_bus_pkg::FAST_TICK_DIV - 1);
  localparam logic [10:0] SLOW_LAST = 11'(pwm_bus_pkg::SLOW_TICK_DIV - 1);

  logic line_s;
  logic line_d;
  logic fall;
  logic rise;
  logic [5:0] fast_div;
  logic [10:0] slow_div;
  logic fast_tick;
  logic slow_tick;
  logic [15:0] sync_hw_control;
  logic [15:0] sync_hw_status;
  logic [15:0] free_running_sync_timer;
  logic [15:0] low_width_timer;
  logic low_running;
  logic [15:0] edge_capture_snapshot;
  logic [15:0] pulse_end_compare_target;
  logic line_drive;
  logic pwm_mode;
  logic cmp_hit;
  logic do_write;
  logic [15:0] status_clear;
  logic [15:0] status_set;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // Merge the low two byte lanes of a write into a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
    lane_merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  // ==========================================================================
  // Line sampling and edge detection
  // ==========================================================================
  pwm_line_sync u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(bus.line),
    .dout(line_s)
  );

  // Delayed copy of the synchronised level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      line_d <= 1'b1;
    else
      line_d <= line_s;
  end

  assign fall = line_d && !line_s;
  assign rise = !line_d && line_s;
  assign pwm_mode = sync_hw_control[pwm_bus_pkg::CTL_PWM_MODE];

  // ==========================================================================
  // Timer clock dividers
  // ==========================================================================
  // 5 MHz tick for the sync timer
  always_ff @(posedge aclk)
  begin
    if (!aresetn || fast_tick)
      fast_div <= '0;
    else
      fast_div <= fast_div + 6'h01;
  end

  // 131 kHz tick for the low-width timer
  always_ff @(posedge aclk)
  begin
    if (!aresetn || slow_tick)
      slow_div <= '0;
    else
      slow_div <= slow_div + 11'h001;
  end

  assign fast_tick = (fast_div == FAST_LAST);
  assign slow_tick = (slow_div == SLOW_LAST);

  // ==========================================================================
  // Sync timer, capture and compare
  // ==========================================================================
  // Free-running count in PWM mode, held at zero while PWM mode is off
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !pwm_mode)
      free_running_sync_timer <= pwm_bus_pkg::REG16_RESET;
    else if (fast_tick)
      free_running_sync_timer <= free_running_sync_timer + 16'h0001;
  end

  // Snapshot of the timer at each bus falling edge in PWM mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      edge_capture_snapshot <= pwm_bus_pkg::REG16_RESET;
    else if (pwm_mode && fall)
      edge_capture_snapshot <= free_running_sync_timer;
  end

  // Match on the tick that moves the timer onto the target; the 16-bit sum wraps
  assign cmp_hit = pwm_mode && sync_hw_control[pwm_bus_pkg::CTL_CMP_EN] && fast_tick &&
                   ((free_running_sync_timer + 16'h0001) == pulse_end_compare_target);

  // ==========================================================================
  // Low-width timer
  // ==========================================================================
  // Cleared on the fall, counts slow ticks, frozen on the rise
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !pwm_mode)
    begin
      low_width_timer <= pwm_bus_pkg::REG16_RESET;
      low_running <= 1'b0;
    end
    else if (fall)
    begin
      low_width_timer <= pwm_bus_pkg::REG16_RESET;
      low_running <= 1'b1;
    end
    else if (rise)
      low_running <= 1'b0;
    else if (low_running && slow_tick)
      low_width_timer <= low_width_timer + 16'h0001;
  end

  // ==========================================================================
  // Status flags, set wins over write-one-to-clear
  // ==========================================================================
  always_comb
  begin
    status_set = '0;
    status_set[pwm_bus_pkg::STA_CMP] = cmp_hit;
    status_set[pwm_bus_pkg::STA_LOW_DONE] = pwm_mode && rise && low_running;
    status_set[pwm_bus_pkg::STA_START] = fall;
  end

  assign status_clear = (do_write && s_axil_awaddr == pwm_bus_pkg::SYNC_HW_STATUS_ADDR) ?
                        lane_merge(16'h0000, s_axil_wdata, s_axil_wstrb) : 16'h0000;

  // Sticky event flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_hw_status <= pwm_bus_pkg::REG16_RESET;
    else
      sync_hw_status <= (sync_hw_status & ~status_clear) | status_set;
  end

  // Interrupt when an enabled flag stands; wake on an enabled high-to-low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
      wake <= 1'b0;
    end
    else
    begin
      irq <= (sync_hw_status[pwm_bus_pkg::STA_CMP] &&
              sync_hw_control[pwm_bus_pkg::CTL_CMP_EN]) ||
             (sync_hw_status[pwm_bus_pkg::STA_LOW_DONE] &&
              sync_hw_control[pwm_bus_pkg::CTL_RISE_IE]) ||
             (sync_hw_status[pwm_bus_pkg::STA_START] &&
              sync_hw_control[pwm_bus_pkg::CTL_START_IE]);
      wake <= fall && sync_hw_control[pwm_bus_pkg::CTL_START_IE];
    end
  end

  // ==========================================================================
  // AXI4-Lite write path
  // ==========================================================================
  assign do_write = s_axil_awvalid && s_axil_wvalid && !s_axil_bvalid;
  assign s_axil_awready = do_write;
  assign s_axil_wready = do_write;

  // Writable registers; the capture register ignores writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_hw_control <= pwm_bus_pkg::REG16_RESET;
      pulse_end_compare_target <= pwm_bus_pkg::REG16_RESET;
      line_drive <= 1'b0;
    end
    else if (do_write)
    begin
      if (s_axil_awaddr == pwm_bus_pkg::SYNC_HW_CONTROL_ADDR)
        sync_hw_control <= lane_merge(sync_hw_control, s_axil_wdata, s_axil_wstrb);
      else if (s_axil_awaddr == pwm_bus_pkg::PULSE_END_COMPARE_TARGET_ADDR)
        pulse_end_compare_target <= lane_merge(pulse_end_compare_target, s_axil_wdata,
                                               s_axil_wstrb);
      else if (s_axil_awaddr == pwm_bus_pkg::LINE_DRIVE_ADDR && s_axil_wstrb[0])
        line_drive <= s_axil_wdata[pwm_bus_pkg::LINE_DRIVE_LOW];
    end
  end

  // Write response one cycle after the pair is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= pwm_bus_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axil_bvalid <= 1'b1;
      if (s_axil_awaddr == pwm_bus_pkg::SYNC_HW_CONTROL_ADDR ||
          s_axil_awaddr == pwm_bus_pkg::SYNC_HW_STATUS_ADDR ||
          s_axil_awaddr == pwm_bus_pkg::PULSE_END_COMPARE_TARGET_ADDR ||
          s_axil_awaddr == pwm_bus_pkg::EDGE_CAPTURE_SNAPSHOT_ADDR ||
          s_axil_awaddr == pwm_bus_pkg::LINE_DRIVE_ADDR)
        s_axil_bresp <= pwm_bus_pkg::RESP_OKAY;
      else
        s_axil_bresp <= pwm_bus_pkg::RESP_SLVERR;
    end
    else if (s_axil_bready)
      s_axil_bvalid <= 1'b0;
  end

  // ==========================================================================
  // AXI4-Lite read path
  // ==========================================================================
  assign s_axil_arready = !s_axil_rvalid;

  // Read decode, upper bits zero
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_rresp = pwm_bus_pkg::RESP_OKAY;
    if (s_axil_araddr == pwm_bus_pkg::SYNC_HW_CONTROL_ADDR)
      next_rdata = {16'h0000, sync_hw_control};
    else if (s_axil_araddr == pwm_bus_pkg::SYNC_HW_STATUS_ADDR)
      next_rdata = {16'h0000, sync_hw_status};
    else if (s_axil_araddr == pwm_bus_pkg::SYNC_TIMER_ADDR)
      next_rdata = {16'h0000, free_running_sync_timer};
    else if (s_axil_araddr == pwm_bus_pkg::LOW_WIDTH_TIMER_ADDR)
      next_rdata = {16'h0000, low_width_timer};
    else if (s_axil_araddr == pwm_bus_pkg::LINE_DRIVE_ADDR)
      next_rdata = {31'h00000000, line_drive};
    else if (s_axil_araddr == pwm_bus_pkg::EDGE_CAPTURE_SNAPSHOT_ADDR)
      next_rdata = {16'h0000, edge_capture_snapshot};
    else if (s_axil_araddr == pwm_bus_pkg::PULSE_END_COMPARE_TARGET_ADDR)
      next_rdata = {16'h0000, pulse_end_compare_target};
    else
      next_rresp = pwm_bus_pkg::RESP_SLVERR;
  end

  // Read data held until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h00000000;
      s_axil_rresp <= pwm_bus_pkg::RESP_OKAY;
    end
    else if (s_axil_arvalid && !s_axil_rvalid)
    begin
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= next_rdata;
      s_axil_rresp <= next_rresp;
    end
    else if (s_axil_rready)
      s_axil_rvalid <= 1'b0;
  end

  // ==========================================================================
  // Open-drain line drive under software control
  // ==========================================================================
  assign bus.dev_out = 1'b0;
  assign bus.dev_oe = line_drive;
endmodule

// *** include/pwm_bus_pkg.sv ***
// Shared constants, register map and helpers for the pulse-width serial bus assist
package pwm_bus_pkg;

  // ==========================================================================
  // Clock and bit timing
  // ==========================================================================
  localparam int CLK_HZ = 200_000_000;
  localparam int BIT_RATE_BPS = 1200;
  localparam int BIT_PERIOD_CYCLES = CLK_HZ / BIT_RATE_BPS;
  localparam int FRAME_BITS = 19;
  localparam int PAUSE_PULSES = 3;
  localparam int SIXTEENTHS = 16;
  localparam int SYNC_LOW_16THS = 2;
  localparam int ZERO_LOW_16THS = 6;
  localparam int ONE_LOW_16THS = 12;
  localparam int SAMPLE_16THS = 9;
  localparam int HDR_SEND_LAST = 8;
  localparam int DATA_SEND_LAST = 17;

  // ==========================================================================
  // Timer clock rates
  // ==========================================================================
  localparam int FAST_TICK_HZ = 5_000_000;
  localparam int FAST_TICK_DIV = CLK_HZ / FAST_TICK_HZ;
  localparam int SLOW_TICK_HZ = 131_000;
  localparam int SLOW_TICK_DIV = CLK_HZ / SLOW_TICK_HZ;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [31:0] SYNC_HW_CONTROL_ADDR = 32'hffff0780;
  localparam logic [31:0] SYNC_HW_STATUS_ADDR = 32'hffff0784;
  localparam logic [31:0] SYNC_TIMER_ADDR = 32'hffff0788;
  localparam logic [31:0] LOW_WIDTH_TIMER_ADDR = 32'hffff078c;
  localparam logic [31:0] LINE_DRIVE_ADDR = 32'hffff0790;
  localparam logic [31:0] EDGE_CAPTURE_SNAPSHOT_ADDR = 32'hffff0794;
  localparam logic [31:0] PULSE_END_COMPARE_TARGET_ADDR = 32'hffff0798;
  localparam logic [15:0] REG16_RESET = 16'h0000;

  // Control and status field positions
  localparam int CTL_START_IE = 3;
  localparam int CTL_CMP_EN = 5;
  localparam int CTL_PWM_MODE = 6;
  localparam int CTL_RISE_IE = 8;
  localparam int STA_LOW_DONE = 0;
  localparam int STA_START = 1;
  localparam int STA_CMP = 3;
  localparam int LINE_DRIVE_LOW = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Odd count of ones gives one
  function automatic logic parity8(input logic [7:0] v);
    parity8 = ^v;
  endfunction

endpackage

// *** include/pwm_bus_if.sv ***
// Shared open-drain wire between the device end and the remote node
`timescale 1ns/1ps
interface pwm_bus_if;
  logic dev_out;
  logic dev_oe;
  logic node_out;
  logic node_oe;
  logic line;

  // Pulled high unless an end drives a low
  assign line = !((dev_oe && !dev_out) || (node_oe && !node_out));

  modport device (output dev_out, output dev_oe, input line);
  modport node (output node_out, output node_oe, input line);
endinterface

// *** hdl/pwm_line_sync.sv ***
// Two-flop synchroniser for the bus line level
`timescale 1ns/1ps
module pwm_line_sync
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic stage1;

  // ==========================================================================
  // Synchroniser chain, idle high like the wire
  // ==========================================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// *** hdl/pwm_bus_node.sv ***
// Remote node end: bus master that sends request frames and reads slave bits
`timescale 1ns/1ps
module pwm_bus_node
#(
  parameter int PERIOD_CYCLES = pwm_bus_pkg::BIT_PERIOD_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [2:0] slave_addr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic ack_bit,
  output logic parity_error,
  pwm_bus_if.node bus
);
  localparam logic [17:0] PER = 18'(PERIOD_CYCLES);
  localparam logic [17:0] SYNC_LOW = 18'(PERIOD_CYCLES * pwm_bus_pkg::SYNC_LOW_16THS /
                                         pwm_bus_pkg::SIXTEENTHS);
  localparam logic [17:0] ZERO_LOW = 18'(PERIOD_CYCLES * pwm_bus_pkg::ZERO_LOW_16THS /
                                         pwm_bus_pkg::SIXTEENTHS);
  localparam logic [17:0] ONE_LOW = 18'(PERIOD_CYCLES * pwm_bus_pkg::ONE_LOW_16THS /
                                        pwm_bus_pkg::SIXTEENTHS);
  localparam logic [17:0] SAMPLE_AT = 18'(PERIOD_CYCLES * pwm_bus_pkg::SAMPLE_16THS /
                                          pwm_bus_pkg::SIXTEENTHS);
  localparam logic [4:0] PAUSE_N = 5'(pwm_bus_pkg::PAUSE_PULSES);
  localparam logic [4:0] LAST_IDX = 5'(pwm_bus_pkg::PAUSE_PULSES + pwm_bus_pkg::FRAME_BITS - 1);

  typedef enum logic {ST_IDLE, ST_BIT} node_state_e;

  node_state_e state;
  logic [17:0] cnt;
  logic [4:0] idx;
  logic [4:0] fbit;
  logic [18:0] frame;
  logic is_write;
  logic sending;
  logic [17:0] hold;
  logic [9:0] rx;
  logic line_s;
  logic drive_low;

  pwm_line_sync u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(bus.line),
    .dout(line_s)
  );

  // ==========================================================================
  // Per-bit drive decision
  // ==========================================================================
  assign fbit = idx - PAUSE_N;
  // Master sends pause and header; data and parity too on a write
  assign sending = (idx < PAUSE_N) || (fbit <= 5'(pwm_bus_pkg::HDR_SEND_LAST)) ||
                   (is_write && fbit <= 5'(pwm_bus_pkg::DATA_SEND_LAST));
  // Coded low time; a listened bit is opened with a sync-length low
  always_comb
  begin
    hold = SYNC_LOW;
    if (idx >= PAUSE_N && sending)
      hold = frame[5'd18 - fbit] ? ONE_LOW : ZERO_LOW;
  end

  // ==========================================================================
  // Frame sequencer
  // ==========================================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      idx <= '0;
      frame <= '0;
      is_write <= 1'b0;
      drive_low <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        ST_IDLE:
          if (start)
          begin
            // Direction 0, address, register, header parity, data, data parity, ack slot
            frame <= {1'b0, slave_addr, reg_addr,
                      pwm_bus_pkg::parity8({1'b0, slave_addr, reg_addr}),
                      wdata, pwm_bus_pkg::parity8(wdata), 1'b1};
            is_write <= reg_addr[3];
            state <= ST_BIT;
            cnt <= '0;
            idx <= '0;
            drive_low <= 1'b1;
          end
        ST_BIT:
          if (cnt == PER - 18'd1)
          begin
            cnt <= '0;
            if (idx == LAST_IDX)
            begin
              state <= ST_IDLE;
              drive_low <= 1'b0;
              done <= 1'b1;
            end
            else
            begin
              idx <= idx + 5'd1;
              drive_low <= 1'b1;
            end
          end
          else
          begin
            cnt <= cnt + 18'd1;
            if (cnt + 18'd1 == hold)
              drive_low <= 1'b0;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Sample bits supplied by the slave between zero and one times
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (state == ST_IDLE && start))
      rx <= '0;
    else if (state == ST_BIT && !sending && cnt == SAMPLE_AT)
      rx <= {rx[8:0], !line_s};
  end

  // Results latched as the frame ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata <= 8'h00;
      ack_bit <= 1'b1;
      parity_error <= 1'b0;
    end
    else if (state == ST_BIT && cnt == PER - 18'd1 && idx == LAST_IDX)
    begin
      ack_bit <= rx[0];
      if (!is_write)
      begin
        rdata <= rx[9:2];
        parity_error <= pwm_bus_pkg::parity8(rx[9:2]) != rx[1];
      end
      else
        parity_error <= 1'b0;
    end
  end

  assign busy = (state != ST_IDLE);
  assign bus.node_out = 1'b0;
  assign bus.node_oe = drive_low;
endmodule

// *** verif/pwm_bus_sva.sv ***
// Checker for the shared pulse-width bus wire
`timescale 1ns/1ps
module pwm_bus_sva
#(
  parameter int PERIOD_CYCLES = pwm_bus_pkg::BIT_PERIOD_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic node_out,
  input wire logic node_oe,
  input wire logic line
);
  localparam int SYNC_N = PERIOD_CYCLES * 2 / 16;
  localparam int ZERO_N = PERIOD_CYCLES * 6 / 16;
  localparam int ONE_N = PERIOD_CYCLES * 12 / 16;
  int low_cnt;
  int gap;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Wire checks
  // ==========================================================================
  // Node low-pulse length and cycles since its last pulse began
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_cnt <= 0;
      gap <= PERIOD_CYCLES;
    end
    else
    begin
      low_cnt <= node_oe ? low_cnt + 1 : 0;
      gap <= (node_oe && low_cnt == 0) ? 1 : (gap < PERIOD_CYCLES ? gap + 1 : gap);
    end
  end

  drive_only_low_a: assert property (!dev_out && !node_out)
    else $error("an end drives the wire high");
  wire_low_a: assert property ((dev_oe || node_oe) |-> !line)
    else $error("wire not low while pulled");
  wire_idle_a: assert property ((!dev_oe && !node_oe) |-> line)
    else $error("wire not high when released");
  pulse_width_a: assert property ($fell(node_oe) |-> low_cnt inside {SYNC_N, ZERO_N, ONE_N})
    else $error("node pulse width off");
  bit_spacing_a: assert property ((node_oe && low_cnt == 0) |-> gap == PERIOD_CYCLES)
    else $error("bit periods too close");
  hold_low_a: assert property ($rose(node_oe) |-> node_oe [*8])
    else $error("node pulse cut short");
  pulse_max_a: assert property (node_oe |-> low_cnt < ONE_N)
    else $error("node pulse too long");
  reset_idle_a: assert property ($rose(aresetn) |-> !node_oe && !dev_oe)
    else $error("wire pulled after reset");

  zero_pulse_c: cover property ($fell(node_oe) && low_cnt == ZERO_N);
  one_pulse_c: cover property ($fell(node_oe) && low_cnt == ONE_N);
  stretch_c: cover property (node_oe && dev_oe);
endmodule

// *** verif/test_pwm_bit_serial_timing_assist.sv ***
// Testbench: device end and remote node joined over the shared wire
`timescale 1ns/1ps
module test_pwm_bit_serial_timing_assist;
  localparam int PER = 160;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic start = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rv;
  logic [2:0] sa = 3'h0;
  logic [3:0] ra = 4'h0;
  logic [7:0] nwd = 8'h0, nrd;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, irq, wake, busy, done, ack_bit, parity_error;
  int errors = 0, checked = 0, wakes = 0, cyc = 0, lw = 0;
  int syms[$];

  // ==========================================================================
  // Both ends and the checker
  // ==========================================================================
  pwm_bus_if bus_if();
  pwm_sync_assist pwm_sync_assist_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .irq(irq), .wake(wake), .bus(bus_if.device));
  pwm_bus_node #(.PERIOD_CYCLES(PER)) pwm_bus_node_inst (.aclk(aclk), .aresetn(aresetn),
    .start(start), .slave_addr(sa), .reg_addr(ra), .wdata(nwd), .busy(busy), .done(done),
    .rdata(nrd), .ack_bit(ack_bit), .parity_error(parity_error), .bus(bus_if.node));
  pwm_bus_sva #(.PERIOD_CYCLES(PER)) pwm_bus_sva_inst (.aclk(aclk), .aresetn(aresetn),
    .dev_out(bus_if.dev_out), .dev_oe(bus_if.dev_oe), .node_out(bus_if.node_out),
    .node_oe(bus_if.node_oe), .line(bus_if.line));

  // Clock
  always #2.5 aclk = ~aclk;

  // Cycle count, wake pulses and low-time symbols on the wire
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (wake === 1'b1)
      wakes <= wakes + 1;
    if (bus_if.line === 1'b0)
      lw <= lw + 1;
    else
    begin
      if (lw > 0)
        syms.push_back(lw < 40 ? 2 : (lw < 90 ? 0 : 1));
      lw <= 0;
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic report_and_stop;
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic limit(input int n, input int m);
    if (n >= m)
    begin
      errors++;
      report_and_stop;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1 && ++n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1 && ++n < 50);
    bready <= 1'b0;
    rs = bresp;
    limit(n, 50);
  endtask

  task automatic rd(input logic [31:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1 && ++n < 50);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1 && ++n < 50);
    rready <= 1'b0;
    rv = rdata;
    rs = rresp;
    limit(n, 50);
  endtask

  task automatic wait_fall;
    int n = 0;
    logic pl;
    do
    begin
      pl = bus_if.line;
      @(posedge aclk);
    end
    while (!(pl === 1'b1 && bus_if.line === 1'b0) && ++n < 400);
    limit(n, 400);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Node frame; the wire symbols are decoded and compared
  task automatic frame(input logic [2:0] a, input logic [3:0] r, input logic [7:0] d);
    logic [17:0] b;
    int n = 0;
    b = {1'b0, a, r, ^{a, r}, d, ^d};
    syms.delete();
    @(posedge aclk);
    start <= 1'b1;
    sa <= a;
    ra <= r;
    nwd <= d;
    @(posedge aclk);
    start <= 1'b0;
    @(posedge aclk);
    check(busy, 32'h1);
    do @(posedge aclk); while (done !== 1'b1 && ++n < 4000);
    limit(n, 4000);
    check(busy, 32'h0);
    check(syms.size(), 32'd22);
    for (int i = 0; i < 3; i++)
      check(syms[i], 32'h2);
    for (int i = 0; i < (r[3] ? 18 : 9); i++)
      check(syms[3 + i], b[17 - i]);
  endtask

  // Device software answers a read as the slave, wire low 12/16 or 6/16 of a period
  task automatic read_case(input logic [2:0] a, input logic [9:0] v, input logic pe);
    fork
      frame(a, 4'h3, 8'h00);
      begin
        repeat (12) wait_fall;
        for (int i = 9; i >= 0; i--)
        begin
          wait_fall;
          wr(32'hffff0790, 32'h1);
          repeat (v[i] ? 114 : 54) @(posedge aclk);
          wr(32'hffff0790, 32'h0);
        end
      end
    join
    check(nrd, v[9:2]);
    check(parity_error, pe);
    check(ack_bit, v[0]);
  endtask

  // Registers, mode off, capture, wake, low width, then compare
  task automatic dev_test;
    int t, w, n = 0;
    rd(32'hffff0798);
    check(rv, 32'h0);
    wr(32'hffff0794, 32'hffffffff);
    check(rs, pwm_bus_pkg::RESP_OKAY);
    rd(32'hffff0794);
    check(rv, 32'h0);
    check(rs, pwm_bus_pkg::RESP_OKAY);
    wr(32'hffff07a0, 32'h1);
    check(rs, pwm_bus_pkg::RESP_SLVERR);
    rd(32'hffff07a0);
    check(rs, pwm_bus_pkg::RESP_SLVERR);
    wr(32'hffff0790, 32'h1);
    repeat (20) @(posedge aclk);
    rd(32'hffff0794);
    check(rv, 32'h0);
    rd(32'hffff0788);
    check(rv, 32'h0);
    wr(32'hffff0790, 32'h0);
    repeat (5) @(posedge aclk);
    rd(32'hffff0784);
    check(rv, 32'h2);
    wr(32'hffff0780, 32'h148);
    wr(32'hffff0784, 32'hb);
    rd(32'hffff0788);
    t = rv;
    w = wakes;
    wr(32'hffff0790, 32'h1);
    repeat (3200) @(posedge aclk);
    wr(32'hffff0790, 32'h0);
    repeat (10) @(posedge aclk);
    rd(32'hffff0794);
    check(32'(rv >= t && rv <= t + 2), 32'h1);
    rd(32'hffff0784);
    check({irq, rv[3:0]}, 5'h13);
    check(wakes - w, 32'h1);
    rd(32'hffff078c);
    check(32'(rv inside {2, 3}), 32'h1);
    wr(32'hffff0784, 32'hb);
    wr(32'hffff0780, 32'h60);
    rd(32'hffff0788);
    t = cyc;
    wr(32'hffff0798, rv + 32'h14);
    do rd(32'hffff0784); while (rv[3] !== 1'b1 && ++n < 400);
    limit(n, 400);
    check(32'((cyc - t) inside {[740:830]}), 32'h1);
    check(irq, 32'h1);
    wr(32'hffff0784, 32'h8);
    rd(32'hffff0784);
    check({rv[3], irq}, 2'h0);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    dev_test;
    frame(3'h5, 4'ha, 8'h96);
    read_case(3'h2, 10'h294, 1'b0);
    read_case(3'h7, 10'h0f3, 1'b1);
    report_and_stop;
  end
endmodule
